// *** rtl/imscbs_pkg.sv ***
package imscbs_pkg;
	// Register word index on the Avalon slave
	localparam int AW = 4;
	localparam logic [AW-1:0] REG_RELOAD = 4'h0;
	localparam logic [AW-1:0] REG_BUFFER = 4'h1;
	localparam logic [AW-1:0] REG_CTRL1 = 4'h2;
	localparam logic [AW-1:0] REG_CTRL2 = 4'h3;
	localparam logic [AW-1:0] REG_CTRL3 = 4'h4;
	localparam logic [AW-1:0] REG_MASK = 4'h5;
	localparam logic [AW-1:0] REG_STATUS = 4'h6;
	localparam logic [AW-1:0] REG_FLAGS = 4'h7;
	// Field positions
	localparam int ST_SMP = 7;
	localparam int ST_CKE = 6;
	localparam int C1_WCOL = 7;
	localparam int C1_EN = 5;
	localparam int C1_CKP = 4;
	localparam int C2_ACK = 4;
	localparam int C2_RCV = 3;
	localparam int C2_STOP = 2;
	localparam int C2_RESTART = 1;
	localparam int C2_START = 0;
	localparam int FL_EVENT = 0;
	localparam int FL_COLL = 1;
	// Mode codes
	localparam logic [3:0] MODE_I2C_MST = 4'h8;
	localparam logic [3:0] MODE_SPI_BRG = 4'ha;
	// Reset values
	localparam logic [7:0] REG8_RST = 8'h00;
	localparam logic SCLK_IDLE = 1'h1;
	localparam logic BUS_IDLE = 1'h1;
	// Baud counter steps once per STEP_DIV clocks
	localparam int STEP_DIV = 2;
	localparam int STEP_W = $clog2(STEP_DIV);

	function automatic logic is_i2c(input logic [3:0] m);
		return m inside {4'h6, 4'h7, 4'h8, 4'hb, 4'he, 4'hf};
	endfunction : is_i2c

	function automatic logic is_spi_master(input logic [3:0] m);
		return m inside {4'h0, 4'h1, 4'h2, 4'h3, 4'ha};
	endfunction : is_spi_master

	function automatic logic is_ten_bit(input logic [3:0] m);
		return m inside {4'h7, 4'hf};
	endfunction : is_ten_bit
endpackage : imscbs_pkg

// *** rtl/imscbs_baud_counter.sv ***
`timescale 1ns/1ns
`default_nettype none
module imscbs_baud_counter (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic step_in,
	input wire logic run_in,
	input wire logic load_in,
	input wire logic [7:0] reload_in,
	output logic expire_out
);
	import imscbs_pkg::*;
	logic [7:0] cnt_q;

	assign expire_out = run_in & step_in & ~load_in & (cnt_q == 8'h00);

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			cnt_q <= REG8_RST;
		end else if (load_in) begin
			cnt_q <= reload_in;
		end else if (run_in && step_in) begin
			if (cnt_q == 8'h00) begin
				cnt_q <= reload_in; // [R9] [R11]
			end else begin
				cnt_q <= cnt_q - 8'h01; // [R11]
			end
		end
	end
endmodule : imscbs_baud_counter
`default_nettype wire

// *** rtl/imscbs_bus_watch.sv ***
`timescale 1ns/1ns
`default_nettype none
module imscbs_bus_watch (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic start_det_out,
	output logic stop_det_out
);
	import imscbs_pkg::*;
	logic scl_prev_q;
	logic sda_prev_q;

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			scl_prev_q <= BUS_IDLE;
			sda_prev_q <= BUS_IDLE;
		end else begin
			scl_prev_q <= scl_in;
			sda_prev_q <= sda_in;
		end
	end

	// Data edges while the clock stays high
	assign start_det_out = scl_in & scl_prev_q & sda_prev_q & ~sda_in;
	assign stop_det_out = scl_in & scl_prev_q & ~sda_prev_q & sda_in;
endmodule : imscbs_bus_watch
`default_nettype wire

// *** rtl/imscbs_top.sv ***
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1: Stop request first drives data low while clock is held low.
// R2: Data low releases clock; clock high loads baud counter; expiry samples data.
// R3: Data still low after release and counter expiry flags a collision.
// R4: Clock sampled low before data floats high flags a collision.
// R5: Any condition collision aborts, releases both lines, clears request bits.
// R6: Baud counter clocks I2C master and SPI master, reloading from reload register.
// R7: Writing the shift buffer starts the baud counter.
// R8: Operation done stops the counter; serial clock keeps its last level.
// R9: Counter reloads twice per serial clock period.
// R10: Serial clock equals oscillator over four times reload plus one.
// R11: Counter decrements on a divided enable and reloads at zero.
// R12: Software avoids reload values 0, 1, 2 in I2C use.
// R13: SPI master: status bit 7 picks late or middle input sampling.
// R14: I2C: status bit 7 set disables slew control, clear enables it.
// R15: SPI: status bit 6 picks transmit edge.
// R16: I2C: status bit 6 selects SMBus input thresholds.
// R17: I2C: status bit 5 tells data versus address for last byte.
// R18: Status bit 4 marks stop seen last; cleared by reset and disable.
// R19: Status bit 3 marks start seen last; cleared by reset and disable.
// R20: I2C slave: status bit 2 holds direction until start, stop or nack.
// R21: I2C master: status bit 2 shows transmit; with requests gives busy.
// R22: Ten-bit mode: status bit 1 asks software to update address.
// R23: Receive: status bit 0 set on full buffer, clear when empty.
// R24: I2C transmit: status bit 0 set while data bits shift out.
// R25: Mode code 1000 selects I2C master clocked by the baud counter.
module imscbs_top (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic [imscbs_pkg::AW-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	output logic sclk_out,
	output logic baud_edge_out,
	output logic [7:0] shift_buffer_out,
	output logic [4:0] request_out,
	output logic port_enable_out,
	output logic [3:0] port_mode_out,
	output logic slew_limit_out,
	output logic smbus_levels_out,
	output logic spi_sample_late_out,
	output logic spi_tx_active_idle_out,
	output logic busy_out,
	output logic collision_flag_out,
	output logic port_event_flag_out,
	input wire logic xfer_done_in,
	input wire logic rx_byte_done_in,
	input wire logic [7:0] rx_byte_in,
	input wire logic tx_bits_done_in,
	input wire logic last_was_data_in,
	input wire logic addr_match_in,
	input wire logic dir_bit_in,
	input wire logic nack_in,
	input wire logic addr_update_in,
	input wire logic [4:0] cond_done_in,
	input wire logic cond_coll_in
);
	import imscbs_pkg::*;

	typedef enum logic [2:0] {
		P_IDLE, P_SDA_LOW, P_SCL_WAIT, P_SCL_HIGH, P_SDA_REL, P_DONE
	} imscbs_stop_e;

	imscbs_stop_e pst_q;
	logic ack_q, bus_req, wr_go, rd_go;
	logic [7:0] wdata, rd_mux, rdata_q;
	logic wr_reload, wr_buf, wr_c1, wr_c2, wr_c3, wr_mask, wr_stat, wr_flags, rd_buf;
	logic [7:0] reload_q, buf_q, mask_q;
	logic [6:0] ctrl3_q;
	logic wcol_q, en_q, ckp_q;
	logic [3:0] mode_q;
	logic [4:0] req_q, req_d;
	logic [1:0] c2_hi_q;
	logic smp_q, cke_q, stat_p_q, stat_s_q, dir_q, ua_q, bf_q;
	logic ev_flag_q, coll_flag_q, run_q, sclk_q;
	logic [STEP_W-1:0] step_q;
	logic step, brg_exp, brg_run, brg_load;
	logic i2c_m, i2c_mst, spi_brg, brg_mode, stop_act, busy, buf_ok;
	logic stop_coll, stop_done, coll_any, rw_bit, start_det, stop_det;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	// Avalon slave: one wait cycle, then the access completes
	assign bus_req = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = bus_req & ~ack_q;
	assign wr_go = avs_write_in & ack_q;
	assign rd_go = avs_read_in & ack_q;
	assign wdata = avs_writedata_in[7:0];
	assign wr_reload = wr_go && (avs_address_in == REG_RELOAD);
	assign wr_buf = wr_go && (avs_address_in == REG_BUFFER);
	assign wr_c1 = wr_go && (avs_address_in == REG_CTRL1);
	assign wr_c2 = wr_go && (avs_address_in == REG_CTRL2);
	assign wr_c3 = wr_go && (avs_address_in == REG_CTRL3);
	assign wr_mask = wr_go && (avs_address_in == REG_MASK);
	assign wr_stat = wr_go && (avs_address_in == REG_STATUS);
	assign wr_flags = wr_go && (avs_address_in == REG_FLAGS);
	assign rd_buf = rd_go && (avs_address_in == REG_BUFFER);

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			ack_q <= 1'h0;
		end else begin
			ack_q <= bus_req & ~ack_q;
		end
	end

	always_comb begin
		rd_mux = REG8_RST;
		case (avs_address_in)
			REG_RELOAD: rd_mux = reload_q;
			REG_BUFFER: rd_mux = buf_q;
			REG_CTRL1: rd_mux = {wcol_q, 1'h0, en_q, ckp_q, mode_q};
			REG_CTRL2: rd_mux = {c2_hi_q[1], 1'h0, c2_hi_q[0], req_q};
			REG_CTRL3: rd_mux = {1'h0, ctrl3_q};
			REG_MASK: rd_mux = mask_q;
			REG_STATUS: rd_mux = {smp_q, cke_q, i2c_m & last_was_data_in, // [R17]
				stat_p_q, stat_s_q, rw_bit, ua_q, bf_q};
			REG_FLAGS: rd_mux = {6'h00, coll_flag_q, ev_flag_q};
			default: rd_mux = REG8_RST;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			rdata_q <= REG8_RST;
		end else if (avs_read_in && !ack_q) begin
			rdata_q <= rd_mux;
		end
	end
	assign avs_readdata_out = {24'h000000, rdata_q};

	// Mode decode
	assign i2c_m = en_q & is_i2c(mode_q);
	assign i2c_mst = en_q & (mode_q == MODE_I2C_MST); // [R25]
	assign spi_brg = en_q & (mode_q == MODE_SPI_BRG);
	assign brg_mode = i2c_mst | spi_brg; // [R6]
	assign stop_act = (pst_q != P_IDLE);
	assign busy = i2c_mst & (run_q | (|req_q)); // [R21]
	assign rw_bit = i2c_mst ? run_q : (i2c_m & dir_q); // [R20] [R21]
	// Buffer writes are refused during a stop sequence or while the I2C master is busy; an SPI transfer does not block them
	assign buf_ok = wr_buf & en_q & ~stop_act & ~busy;

	// Plain control storage
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			reload_q <= REG8_RST;
			mask_q <= REG8_RST;
			ctrl3_q <= 7'h00;
			{en_q, ckp_q, mode_q} <= 6'h00;
			c2_hi_q <= 2'h0;
			{smp_q, cke_q} <= 2'h0;
		end else begin
			if (wr_reload) begin
				reload_q <= wdata; // [R6]
			end
			if (wr_mask) begin
				mask_q <= wdata;
			end
			if (wr_c3) begin
				ctrl3_q <= wdata[6:0];
			end
			if (wr_c1) begin
				{en_q, ckp_q, mode_q} <= wdata[C1_EN:0];
			end
			if (wr_c2) begin
				c2_hi_q <= {wdata[7], wdata[5]};
			end
			if (wr_stat) begin
				{smp_q, cke_q} <= {wdata[ST_SMP], wdata[ST_CKE]};
			end
		end
	end

	assign spi_sample_late_out = en_q & is_spi_master(mode_q) & smp_q; // [R13]
	assign slew_limit_out = i2c_m & ~smp_q; // [R14]
	assign spi_tx_active_idle_out = en_q & ~is_i2c(mode_q) & cke_q; // [R15]
	assign smbus_levels_out = i2c_m & cke_q; // [R16]

	// Counter step enable
	assign step = (step_q == STEP_W'(STEP_DIV - 1));
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			step_q <= '0;
		end else if (step) begin
			step_q <= '0;
		end else begin
			step_q <= step_q + STEP_W'(1);
		end
	end

	assign brg_run = run_q | (pst_q inside {P_SCL_HIGH, P_SDA_REL, P_DONE});
	assign brg_load = (buf_ok & brg_mode) | (pst_q == P_SCL_WAIT & scl_in); // [R7] [R2]

	imscbs_baud_counter u_baud (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.step_in(step),
		.run_in(brg_run),
		.load_in(brg_load),
		.reload_in(reload_q),
		.expire_out(brg_exp)
	);

	imscbs_bus_watch u_watch (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.start_det_out(start_det),
		.stop_det_out(stop_det)
	);

	assign baud_edge_out = brg_exp;

	// Transfer run and serial clock level
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			run_q <= 1'h0;
		end else if (buf_ok && brg_mode) begin
			run_q <= 1'h1; // [R7]
		end else if (xfer_done_in || !brg_mode || coll_any) begin
			run_q <= 1'h0; // [R8]
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in || !en_q) begin
			sclk_q <= SCLK_IDLE;
		end else if (coll_any || stop_done) begin
			sclk_q <= SCLK_IDLE; // [R5]
		end else if (run_q && brg_exp) begin
			sclk_q <= ~sclk_q; // [R9] [R10]
		end
	end

	run_hold_a: assert property ((!run_q && !stop_act && en_q && !coll_any && !wr_c1)
		|=> $stable(sclk_q)) else $error("serial clock moved while idle"); // [R8]

	// Stop sequence
	assign stop_coll = (pst_q == P_SCL_HIGH && !scl_in) // [R4]
		|| (pst_q == P_SDA_REL && !sda_in && (!scl_in || brg_exp)); // [R3] [R4]
	assign stop_done = (pst_q == P_DONE) && brg_exp;
	assign coll_any = stop_coll | (cond_coll_in & i2c_mst);

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in || !i2c_mst || coll_any) begin
			pst_q <= P_IDLE; // [R5]
		end else begin
			unique case (pst_q)
				P_IDLE: begin
					if (req_q[C2_STOP] && !run_q) begin
						pst_q <= P_SDA_LOW; // [R1]
					end
				end
				P_SDA_LOW: begin
					if (!sda_in) begin
						pst_q <= P_SCL_WAIT; // [R2]
					end
				end
				P_SCL_WAIT: begin
					if (scl_in) begin
						pst_q <= P_SCL_HIGH; // [R2]
					end
				end
				P_SCL_HIGH: begin
					if (brg_exp) begin
						pst_q <= P_SDA_REL;
					end
				end
				P_SDA_REL: begin
					if (brg_exp) begin
						pst_q <= P_DONE; // [R3]
					end
				end
				P_DONE: begin
					if (brg_exp) begin
						pst_q <= P_IDLE;
					end
				end
			endcase
		end
	end

	// Lines are open drain: only ever pulled low
	assign scl_out = 1'h0;
	assign sda_out = 1'h0;
	assign sda_oe_out = pst_q inside {P_SDA_LOW, P_SCL_WAIT, P_SCL_HIGH}; // [R1]
	assign scl_oe_out = i2c_mst & (stop_act ? (pst_q == P_SDA_LOW) : ~sclk_q); // [R1] [R2]
	assign sclk_out = sclk_q;

	stop_entry_a: assert property ((pst_q == P_IDLE && req_q[C2_STOP] && !run_q && i2c_mst
		&& !coll_any && !wr_c1) |=> sda_oe_out && scl_oe_out)
		else $error("stop did not pull data and clock low"); // [R1]
	scl_release_a: assert property ((pst_q == P_SDA_LOW && !sda_in && !coll_any && !wr_c1)
		|=> !scl_oe_out && sda_oe_out) else $error("clock not released on data low"); // [R2]
	late_data_a: assert property ((pst_q == P_SDA_REL && brg_exp && !sda_in)
		|=> coll_flag_q && !req_q[C2_STOP] && !sda_oe_out && !scl_oe_out)
		else $error("data low after release not flagged"); // [R3]
	early_clock_a: assert property ((pst_q == P_SCL_HIGH && !scl_in)
		|=> coll_flag_q && pst_q == P_IDLE) else $error("clock low before data release missed"); // [R4]
	abort_release_a: assert property (coll_any |=> req_q == 5'h00 && !sda_oe_out)
		else $error("collision left requests or data drive"); // [R5]

	// Request bits: software sets only when idle, hardware clears
	always_comb begin
		req_d = req_q;
		if (wr_c2 && i2c_mst && !busy) begin
			req_d = wdata[4:0];
		end else if (wr_c2 && !i2c_mst) begin
			req_d = {4'h0, wdata[C2_START]};
		end
		if (i2c_mst) begin
			req_d = req_d & ~{cond_done_in[4:3], 1'h0, cond_done_in[1:0]};
		end
		if (stop_done) begin
			req_d[C2_STOP] = 1'h0;
		end
		if (coll_any || (!i2c_mst && !i2c_m)) begin
			req_d = 5'h00; // [R5]
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			req_q <= 5'h00;
		end else begin
			req_q <= req_d;
		end
	end

	assign request_out = req_q;
	assign busy_out = busy;
	assign port_enable_out = en_q;
	assign port_mode_out = mode_q;

	// Status bits
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in || !en_q) begin
			stat_p_q <= 1'h0; // [R18]
			stat_s_q <= 1'h0; // [R19]
			dir_q <= 1'h0;
		end else begin
			if (i2c_m && stop_det) begin
				stat_p_q <= 1'h1; // [R18]
				stat_s_q <= 1'h0;
			end else if (i2c_m && start_det) begin
				stat_s_q <= 1'h1; // [R19]
				stat_p_q <= 1'h0;
			end
			if (addr_match_in) begin
				dir_q <= dir_bit_in; // [R20]
			end else if (start_det || stop_det || nack_in) begin
				dir_q <= 1'h0; // [R20]
			end
		end
	end

	en_clear_a: assert property (!en_q |=> !stat_p_q && !stat_s_q)
		else $error("start or stop status kept while disabled"); // [R18] [R19]

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in || !en_q || !is_ten_bit(mode_q)) begin
			ua_q <= 1'h0;
		end else if (addr_update_in) begin
			ua_q <= 1'h1; // [R22]
		end else if (wr_reload) begin
			ua_q <= 1'h0;
		end
	end

	// Buffer and full flag; a set in the clearing cycle wins
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			buf_q <= REG8_RST;
		end else if (rx_byte_done_in && en_q) begin
			buf_q <= rx_byte_in;
		end else if (buf_ok) begin
			buf_q <= wdata;
		end
	end
	assign shift_buffer_out = buf_q;

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in || !en_q) begin
			bf_q <= 1'h0;
		end else if (rx_byte_done_in) begin
			bf_q <= 1'h1; // [R23]
		end else if (buf_ok && i2c_m) begin
			bf_q <= 1'h1; // [R24]
		end else if (rd_buf || tx_bits_done_in || coll_any) begin
			bf_q <= 1'h0; // [R23] [R24]
		end
	end

	bf_rx_a: assert property ((rx_byte_done_in && en_q)
		|=> bf_q && shift_buffer_out == $past(rx_byte_in)) else $error("received byte not held"); // [R23]
	buf_start_a: assert property ((buf_ok && brg_mode) |=> run_q)
		else $error("buffer write did not start counter"); // [R7]

	// Sticky flags cleared by writing zero
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			wcol_q <= 1'h0;
			ev_flag_q <= 1'h0;
			coll_flag_q <= 1'h0;
		end else begin
			if (wr_buf && en_q && !buf_ok) begin
				wcol_q <= 1'h1;
			end else if (wr_c1 && !wdata[C1_WCOL]) begin
				wcol_q <= 1'h0;
			end
			if (stop_done || (xfer_done_in && brg_mode)) begin
				ev_flag_q <= 1'h1;
			end else if (wr_flags && !wdata[FL_EVENT]) begin
				ev_flag_q <= 1'h0;
			end
			if (coll_any) begin
				coll_flag_q <= 1'h1; // [R3] [R4]
			end else if (wr_flags && !wdata[FL_COLL]) begin
				coll_flag_q <= 1'h0;
			end
		end
	end

	assign collision_flag_out = coll_flag_q;
	assign port_event_flag_out = ev_flag_q;
endmodule : imscbs_top
`default_nettype wire

// *** tb/imscbs_bus_peer.sv ***
`timescale 1ns/1ns
`default_nettype none
module imscbs_bus_peer (
	input wire logic mclk_in,
	input wire logic scl_oe_in,
	input wire logic sda_oe_in,
	input wire logic pull_scl_in,
	input wire logic pull_sda_in,
	input wire logic [3:0] stretch_in,
	output logic scl_out,
	output logic sda_out
);
	logic [3:0] hold_q = 4'h0;
	logic oe_q = 1'b0;
	logic release_now;

	// A slow peer keeps the clock low for a while after the master lets go
	assign release_now = oe_q & ~scl_oe_in & (stretch_in != 4'h0);
	always_ff @(posedge mclk_in) begin
		oe_q <= scl_oe_in;
		if (oe_q && !scl_oe_in)
			hold_q <= stretch_in;
		else if (hold_q != 4'h0)
			hold_q <= hold_q - 4'h1;
	end
	// Wired-AND with pull-ups: a released line floats high
	assign scl_out = ~(scl_oe_in | pull_scl_in | (hold_q != 4'h0) | release_now);
	assign sda_out = ~(sda_oe_in | pull_sda_in);
endmodule : imscbs_bus_peer
`default_nettype wire

// *** tb/imscbs_top_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module imscbs_top_tb;
	import imscbs_pkg::*;
	// Three and above only: lower values are not usable for I2C timing
	localparam logic [7:0] RELOAD = 8'h04;
	logic mclk_in, sys_rst_in, avs_read_in, avs_write_in, scl_in, sda_in;
	logic [AW-1:0] avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, rdata;
	logic avs_waitrequest_out, scl_oe_out, sda_oe_out, sclk_out, baud_edge_out;
	logic [7:0] shift_buffer_out, rx_byte_in;
	logic [4:0] request_out, cond_done_in;
	logic [3:0] port_mode_out, stretch;
	logic port_enable_out, slew_limit_out, smbus_levels_out, spi_sample_late_out;
	logic spi_tx_active_idle_out, busy_out, collision_flag_out, port_event_flag_out;
	logic xfer_done_in, rx_byte_done_in, tx_bits_done_in, last_was_data_in;
	logic addr_match_in, dir_bit_in, nack_in, addr_update_in, cond_coll_in;
	logic pull_scl, pull_sda, s;
	int n_errors = 0;
	int tests_run = 0;
	int n;
	logic [23:0] rows [8] = '{
		{REG_RELOAD, RELOAD, RELOAD, 4'h0}, {REG_MASK, 8'ha5, 8'ha5, 4'h0},
		{REG_CTRL3, 8'hff, 8'h7f, 4'h0}, {4'h9, 8'hff, 8'h00, 4'h0},
		{REG_STATUS, 8'hff, 8'hc0, 4'h0}, {REG_CTRL1, 8'h2a, 8'h2a, 4'h3},
		{REG_CTRL1, 8'h28, 8'h28, 4'h4}, {REG_STATUS, 8'h00, 8'h00, 4'h8}};

	imscbs_top uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.scl_in(scl_in), .scl_out(), .scl_oe_out(scl_oe_out), .sda_in(sda_in),
		.sda_out(), .sda_oe_out(sda_oe_out), .sclk_out(sclk_out),
		.baud_edge_out(baud_edge_out), .shift_buffer_out(shift_buffer_out),
		.request_out(request_out), .port_enable_out(port_enable_out),
		.port_mode_out(port_mode_out), .slew_limit_out(slew_limit_out),
		.smbus_levels_out(smbus_levels_out), .spi_sample_late_out(spi_sample_late_out),
		.spi_tx_active_idle_out(spi_tx_active_idle_out), .busy_out(busy_out),
		.collision_flag_out(collision_flag_out), .port_event_flag_out(port_event_flag_out),
		.xfer_done_in(xfer_done_in), .rx_byte_done_in(rx_byte_done_in),
		.rx_byte_in(rx_byte_in), .tx_bits_done_in(tx_bits_done_in),
		.last_was_data_in(last_was_data_in), .addr_match_in(addr_match_in),
		.dir_bit_in(dir_bit_in), .nack_in(nack_in), .addr_update_in(addr_update_in),
		.cond_done_in(cond_done_in), .cond_coll_in(cond_coll_in));

	imscbs_bus_peer peer (.mclk_in(mclk_in), .scl_oe_in(scl_oe_out), .sda_oe_in(sda_oe_out),
		.pull_scl_in(pull_scl), .pull_sda_in(pull_sda), .stretch_in(stretch),
		.scl_out(scl_in), .sda_out(sda_in));

	initial begin
		mclk_in = 1'b0;
		forever #25 mclk_in = ~mclk_in;
	end

	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic bus_xfer(input logic wr_en, input logic [AW-1:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		avs_address_in <= a;
		avs_writedata_in <= {24'h0, d};
		avs_write_in <= wr_en;
		avs_read_in <= ~wr_en;
		// Only the watchdog ends a wait that never completes
		do begin
			@(posedge mclk_in);
		end while (avs_waitrequest_out !== 1'b0);
		rdata = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask : bus_xfer

	task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
		bus_xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [AW-1:0] a);
		bus_xfer(1'b0, a, 8'h00);
	endtask : rd

	function automatic logic sig(input int sel);
		case (sel)
			0: return sda_oe_out;
			1: return scl_oe_out;
			2: return baud_edge_out;
			3: return collision_flag_out;
			default: return port_event_flag_out;
		endcase
	endfunction : sig

	// Bounded wait, then the level itself is compared
	task automatic wait_sig(input int sel, input logic v);
		int k;
		k = 0;
		while (sig(sel) !== v && k < 400) begin
			@(posedge mclk_in);
			k++;
		end
		check({31'h0, sig(sel)}, {31'h0, v});
	endtask : wait_sig

	task automatic pulse(input int sel);
		case (sel)
			0: tx_bits_done_in <= 1'b1;
			1: xfer_done_in <= 1'b1;
			2: addr_update_in <= 1'b1;
			3: addr_match_in <= 1'b1;
			4: rx_byte_done_in <= 1'b1;
			6: cond_coll_in <= 1'b1;
			7: cond_done_in <= 5'h01;
			default: nack_in <= 1'b1;
		endcase
		@(posedge mclk_in);
		{tx_bits_done_in, xfer_done_in, addr_update_in} <= 3'h0;
		{addr_match_in, rx_byte_done_in, nack_in, cond_coll_in} <= 4'h0;
		cond_done_in <= 5'h00;
		// Let an edge pass so a following pulse never reassigns in this step
		@(posedge mclk_in);
	endtask : pulse

	task automatic stop_collision(input logic on_scl);
		wr(REG_CTRL2, 8'h04);
		wait_sig(0, 1'b1);
		wait_sig(1, 1'b0);
		repeat (3) @(posedge mclk_in);
		pull_scl <= on_scl;
		pull_sda <= ~on_scl;
		wait_sig(3, 1'b1);
		check({25'h0, request_out, sda_oe_out, scl_oe_out}, 32'h0);
		pull_scl <= 1'b0;
		pull_sda <= 1'b0;
		wr(REG_FLAGS, 8'h00);
	endtask : stop_collision

	initial begin
		repeat (5000) @(posedge mclk_in);
		n_errors++;
		finish_test();
	end

	initial begin
		sys_rst_in = 1'b1;
		{avs_read_in, avs_write_in, pull_scl, pull_sda} = 4'h0;
		avs_address_in = '0;
		avs_writedata_in = '0;
		{xfer_done_in, rx_byte_done_in, tx_bits_done_in, last_was_data_in} = 4'h0;
		{addr_match_in, dir_bit_in, nack_in, addr_update_in, cond_coll_in} = 5'h0;
		rx_byte_in = 8'h00;
		cond_done_in = 5'h00;
		stretch = 4'h3;
		repeat (4) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		check({31'h0, sclk_out}, 32'h1);
		for (int a = 0; a < 8; a++) begin
			rd(a[AW-1:0]);
			check(rdata, 32'h0);
		end
		// Status written back to 0 before any slave mode
		foreach (rows[i]) begin
			wr(rows[i][23:20], rows[i][19:12]);
			rd(rows[i][23:20]);
			check(rdata, {24'h0, rows[i][11:4]});
			check({28'h0, slew_limit_out, smbus_levels_out, spi_sample_late_out,
				spi_tx_active_idle_out}, {28'h0, rows[i][3:0]});
		end
		wr(REG_BUFFER, 8'h5a);
		rd(REG_STATUS);
		check(rdata & 32'h5, 32'h5);
		check({31'h0, busy_out}, 32'h1);
		wait_sig(2, 1'b1);
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
		end while (baud_edge_out !== 1'b1 && n < 100);
		check(n, 32'(2 * (RELOAD + 1)));
		pulse(0);
		rd(REG_STATUS);
		check(rdata & 32'h1, 32'h0);
		pulse(1);
		@(posedge mclk_in);
		s = sclk_out;
		n = 0;
		repeat (30) begin
			@(posedge mclk_in);
			if (baud_edge_out === 1'b1)
				n++;
		end
		check(n, 0);
		check({31'h0, sclk_out}, {31'h0, s});
		check({31'h0, port_event_flag_out}, 32'h1);
		// Clear it so the stop's own event is what gets seen
		wr(REG_FLAGS, 8'h00);
		wr(REG_CTRL2, 8'h04);
		wait_sig(0, 1'b1);
		check({31'h0, scl_oe_out}, 32'h1);
		wait_sig(1, 1'b0);
		wait_sig(0, 1'b0);
		wait_sig(4, 1'b1);
		check({26'h0, request_out, collision_flag_out}, 32'h0);
		rd(REG_STATUS);
		check(rdata & 32'h18, 32'h10);
		wr(REG_FLAGS, 8'h00);
		stretch <= 4'h0;
		stop_collision(1'b0);
		stop_collision(1'b1);
		wr(REG_CTRL2, 8'h11);
		rd(REG_CTRL2);
		check(rdata, 32'h11);
		pulse(7);
		check({27'h0, request_out}, 32'h10);
		pulse(6);
		check({26'h0, request_out, collision_flag_out}, 32'h1);
		wr(REG_CTRL1, 8'h08);
		rd(REG_STATUS);
		check(rdata & 32'h18, 32'h0);
		wr(REG_CTRL1, 8'h37);
		last_was_data_in <= 1'b1;
		dir_bit_in <= 1'b1;
		rx_byte_in <= 8'h3c;
		pulse(2);
		pulse(3);
		pulse(4);
		rd(REG_STATUS);
		check(rdata, 32'h27);
		rd(REG_BUFFER);
		check(rdata, 32'h3c);
		pulse(5);
		wr(REG_RELOAD, RELOAD);
		rd(REG_STATUS);
		check(rdata, 32'h20);
		finish_test();
	end
endmodule : imscbs_top_tb
`default_nettype wire
